// ### five_channel_capture_compare_array.sv
// Purpose: Shared 16-bit counter with five capture/compare modules
// Assumes: SFR writes and reads are on clk; pins are asynchronous
// Notes:   Read data is registered, valid one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module five_channel_capture_compare_array
  import capcmp_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [7:0]      sfrAddr,
  input  wire logic [7:0]      sfrWrData,
  input  wire logic            sfrWrEn,
  output logic      [7:0]      sfrRdData,
  input  wire logic            idleMode,
  input  wire logic            timer0Overflow,
  input  wire logic            extCountPin,
  input  wire logic [NMOD-1:0] moduleIoPinIn,
  output logic      [NMOD-1:0] moduleIoPinOut,
  output logic      [NMOD-1:0] moduleIoPinOe,
  output logic                 irqReq,
  output logic                 guardReset
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot hit on a run of NMOD consecutive addresses
  function automatic logic [NMOD-1:0] rangeHit(
    input logic [7:0] addr,
    input logic [7:0] base,
    input logic       en
  );
    logic [NMOD-1:0] hit;
    hit = '0;
    for (int i = 0; i < NMOD; i++) begin
      hit[i] = en & (addr == base + 8'(i));
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]      counterMode_q;
  logic            overflowFlag_q;
  logic            counterRun_q;
  logic [NMOD-1:0] eventFlag_q;
  logic [15:0]     counter_q;
  logic [7:0]      moduleMode_q [NMOD];
  logic [7:0]      valueHigh_q  [NMOD];
  logic [7:0]      valueLow_q   [NMOD];
  logic [NMOD-1:0] pinOut_q;
  logic [NMOD-1:0] pinOe_q;
  logic [7:0]      rdData_q;
  logic            irq_q;
  logic            guard_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NMOD:0] pinLevel;
  logic [NMOD:0] pinRise;
  logic [NMOD:0] pinFall;

  // Pin n of the group is module n; top bit is the count input [RQ18]
  pin_sync_edge #(
    .WIDTH    (NMOD + 1)
  ) u_pins (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinAsync ({extCountPin, moduleIoPinIn}),
    .pinLevel (pinLevel),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire             wrMode    = sfrWrEn & (sfrAddr == ADDR_MODE);
  wire             wrControl = sfrWrEn & (sfrAddr == ADDR_CONTROL);
  wire             wrCntLow  = sfrWrEn & (sfrAddr == ADDR_CNT_LOW);
  wire             wrCntHigh = sfrWrEn & (sfrAddr == ADDR_CNT_HIGH);
  wire [NMOD-1:0]  wrModMode = rangeHit(sfrAddr, ADDR_MOD_MODE, sfrWrEn);
  wire [NMOD-1:0]  wrValLow  = rangeHit(sfrAddr, ADDR_VAL_LOW, sfrWrEn);
  wire [NMOD-1:0]  wrValHigh = rangeHit(sfrAddr, ADDR_VAL_HIGH, sfrWrEn);
  wire [NMOD-1:0]  rdModMode = rangeHit(sfrAddr, ADDR_MOD_MODE, 1'b1);
  wire [NMOD-1:0]  rdValLow  = rangeHit(sfrAddr, ADDR_VAL_LOW, 1'b1);
  wire [NMOD-1:0]  rdValHigh = rangeHit(sfrAddr, ADDR_VAL_HIGH, 1'b1);

  // ----------------------------------------------------------------
  // Counter time base
  // ----------------------------------------------------------------
  logic countTick;
  wire  idleGated   = counterMode_q[MODE_IDLE_GATE] & idleMode;   // [RQ4]
  wire  countEnable = counterRun_q & ~idleGated;                  // [RQ7]
  wire  [15:0] counterNext = counter_q + 16'h0001;
  wire  overflowEv  = countTick & (counter_q == 16'hffff);        // [RQ21]
  wire  lowWrapEv   = countTick & (counter_q[7:0] == 8'hff);

  count_tick_gen #(
    .DIV            (PRESCALE_DIV)
  ) u_tick (
    .clk            (clk),
    .rst_n          (rst_n),
    .sourceSel      (counterMode_q[MODE_SRC_HI:MODE_SRC_LO]),     // [RQ2]
    .countEnable    (countEnable),
    .timer0Overflow (timer0Overflow),
    .extFall        (pinFall[NMOD]),
    .countTick      (countTick)
  );

  // External input is edge-detected after sync; needs fclk/4 max [RQ3]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_q <= RESET_CNT;
    end else if (wrCntLow) begin
      counter_q <= {counter_q[15:8], sfrWrData};
    end else if (wrCntHigh) begin
      counter_q <= {sfrWrData, counter_q[7:0]};
    end else if (countTick) begin
      counter_q <= counterNext;                                   // [RQ1]
    end
  end

  // ----------------------------------------------------------------
  // Mode and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counterMode_q <= RESET_REG8;
    end else if (wrMode) begin
      counterMode_q <= sfrWrData & MODE_WR_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counterRun_q <= 1'b0;
    end else if (wrControl) begin
      counterRun_q <= sfrWrData[CTRL_RUN];                        // [RQ7]
    end
  end

  // Hardware set wins over a software clear in the same cycle
  wire ovfFlag_d = overflowEv |                                   // [RQ8]
                   (wrControl ? sfrWrData[CTRL_OVF_FLAG] : overflowFlag_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflowFlag_q <= 1'b0;
    end else begin
      overflowFlag_q <= ovfFlag_d;
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare modules
  // ----------------------------------------------------------------
  logic [NMOD-1:0] matchEv;
  logic [NMOD-1:0] captureEv;
  logic [NMOD-1:0] pwmOn;
  logic [NMOD-1:0] flagSet;
  logic [NMOD-1:0] pinOut_d;

  for (genvar m = 0; m < NMOD; m++) begin : g_mod
    wire [7:0] mm = moduleMode_q[m];
    wire [15:0] value = {valueHigh_q[m], valueLow_q[m]};

    // Match checked against the count being entered [RQ16]
    assign matchEv[m] = mm[MM_CMP_EN] & countTick & (counterNext == value);

    assign captureEv[m] = (mm[MM_RISE_GRAB] & pinRise[m]) |       // [RQ15]
                          (mm[MM_FALL_GRAB] & pinFall[m]);

    assign pwmOn[m] = mm[MM_CMP_EN] & mm[MM_PWM];                 // [RQ12]

    assign flagSet[m] = captureEv[m] |                            // [RQ9]
                        (matchEv[m] & mm[MM_EQ_FLAG]);            // [RQ14]

    // PWM pin is low while the low count is under the duty byte [RQ12]
    assign pinOut_d[m] =
      pwmOn[m] ? (counter_q[7:0] >= valueLow_q[m]) :
      (matchEv[m] & mm[MM_FLIP]) ? ~pinOut_q[m] :                 // [RQ13]
      pinOut_q[m];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        moduleMode_q[m] <= RESET_REG8;
      end else if (wrModMode[m]) begin
        moduleMode_q[m] <= sfrWrData & MM_WR_MASK;
      end
    end

    // Capture has priority over a software write [RQ17]
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        valueHigh_q[m] <= RESET_REG8;
      end else if (captureEv[m]) begin
        valueHigh_q[m] <= counter_q[15:8];                        // [RQ19]
      end else if (wrValHigh[m]) begin
        valueHigh_q[m] <= sfrWrData;
      end
    end

    // Duty byte reloads from the high byte at each low-byte wrap
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        valueLow_q[m] <= RESET_REG8;
      end else if (captureEv[m]) begin
        valueLow_q[m] <= counter_q[7:0];                          // [RQ19]
      end else if (wrValLow[m]) begin
        valueLow_q[m] <= sfrWrData;
      end else if (pwmOn[m] & lowWrapEv) begin
        valueLow_q[m] <= valueHigh_q[m];                          // [RQ12]
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pinOut_q[m] <= RESET_PIN;
        pinOe_q[m]  <= 1'b0;
      end else begin
        pinOut_q[m] <= pinOut_d[m];
        pinOe_q[m]  <= pwmOn[m] | mm[MM_FLIP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Set wins over clear; software may also set a flag
  wire [NMOD-1:0] eventFlag_d =
    flagSet | (wrControl ? sfrWrData[NMOD-1:0] : eventFlag_q);    // [RQ9]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eventFlag_q <= '0;
    end else begin
      eventFlag_q <= eventFlag_d;
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt and module-4 watchdog
  // ----------------------------------------------------------------
  logic [NMOD-1:0] moduleIrqEn;
  for (genvar k = 0; k < NMOD; k++) begin : g_ie
    assign moduleIrqEn[k] = moduleMode_q[k][MM_IRQ_EN];           // [RQ11]
  end

  // One request line for every source [RQ10]
  wire irq_d = (overflowFlag_q & counterMode_q[MODE_OVF_IE]) |    // [RQ6]
               |(eventFlag_q & moduleIrqEn);                      // [RQ22]

  // Guard fires on a module-4 match; software keeps moving the value
  wire guard_d = counterMode_q[MODE_GUARD_EN] & matchEv[NMOD-1];  // [RQ5]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q   <= 1'b0;
      guard_q <= 1'b0;
    end else begin
      irq_q   <= irq_d;
      guard_q <= guard_d;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Reserved bits read as zero; unmapped addresses read zero
  function automatic logic [7:0] readMux(input logic [7:0] addr);
    logic [7:0] r;
    r = 8'h00;
    if (addr == ADDR_MODE) begin
      r = counterMode_q;
    end
    if (addr == ADDR_CONTROL) begin
      r = {overflowFlag_q, counterRun_q, 1'b0, eventFlag_q};
    end
    if (addr == ADDR_CNT_LOW) begin
      r = counter_q[7:0];
    end
    if (addr == ADDR_CNT_HIGH) begin
      r = counter_q[15:8];
    end
    for (int i = 0; i < NMOD; i++) begin
      if (rdModMode[i]) begin
        r = moduleMode_q[i];
      end
      if (rdValLow[i]) begin
        r = valueLow_q[i];
      end
      if (rdValHigh[i]) begin
        r = valueHigh_q[i];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= RESET_REG8;
    end else begin
      rdData_q <= readMux(sfrAddr);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fast-output mode relies on software setting all three bits [RQ20]
  assign sfrRdData      = rdData_q;
  assign moduleIoPinOut = pinOut_q;
  assign moduleIoPinOe  = pinOe_q;
  assign irqReq         = irq_q;
  assign guardReset     = guard_q;

endmodule // five_channel_capture_compare_array
`default_nettype wire

// ### capcmp_pkg.sv
// Purpose: Shared constants of the five-channel capture/compare array
// Assumes: 8-bit special function register bus, 100 MHz clk
// Notes:   Functional notes below, one per line
//
// Functional notes
// RQ1: One free-running 16-bit up counter, read as upper and lower byte.
// RQ2: Source select 0/1 clk divided by 6, 2 timer-0 overflow, 3 external.
// RQ3: External count source toggles no faster than a quarter of clk.
// RQ4: Idle gate bit 0 counts in idle; 1 stops counting in idle.
// RQ5: Module-4 guard enable bit turns the module-4 watchdog on or off.
// RQ6: Overflow irq enable lets the overflow flag request an interrupt.
// RQ7: Counter runs only while control bit 6 is set by software.
// RQ8: Hardware sets overflow flag bit 7; only software clears it.
// RQ9: Control bits 0-4 are module event flags, set by hw, cleared by sw.
// RQ10: All module events and overflow share one interrupt request.
// RQ11: Mode bit 0 lets the module event flag raise the interrupt.
// RQ12: Mode bit 1 selects PWM; duty set by the module value registers.
// RQ13: Mode bit 2 inverts the module pin on each counter/value match.
// RQ14: Mode bit 3 sets the module event flag on each match.
// RQ15: Mode bit 4 captures falling, bit 5 rising edges; both means either.
// RQ16: Mode bit 6 enables the comparator of counter against value.
// RQ17: Each module owns a 16-bit value pair, high and low byte.
// RQ18: Module n sits on port pin n, pins counted upward from module 0.
// RQ19: A valid enabled pin edge copies the counter into the value pair.
// RQ20: Software sets toggle, equal-flag and comparator for fast output.
// RQ21: Overflow is the counter wrapping from all ones to zero.
// RQ22: Interrupt is OR of gated overflow flag and gated module flags.
package capcmp_pkg;

  localparam int NUM_MODULES = 5;

  // Register addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'hd8;
  localparam logic [7:0] ADDR_MODE      = 8'hd9;
  localparam logic [7:0] ADDR_MOD_MODE  = 8'hda;
  localparam logic [7:0] ADDR_CNT_LOW   = 8'he9;
  localparam logic [7:0] ADDR_CNT_HIGH  = 8'hf9;
  localparam logic [7:0] ADDR_VAL_LOW   = 8'hea;
  localparam logic [7:0] ADDR_VAL_HIGH  = 8'hfa;

  // Counter mode register fields
  localparam int MODE_IDLE_GATE   = 7;
  localparam int MODE_GUARD_EN    = 6;
  localparam int MODE_SRC_HI      = 2;
  localparam int MODE_SRC_LO      = 1;
  localparam int MODE_OVF_IE      = 0;
  localparam logic [7:0] MODE_WR_MASK = 8'hc7;

  // Counter control register fields
  localparam int CTRL_OVF_FLAG    = 7;
  localparam int CTRL_RUN         = 6;

  // Module mode register fields
  localparam int MM_CMP_EN        = 6;
  localparam int MM_RISE_GRAB     = 5;
  localparam int MM_FALL_GRAB     = 4;
  localparam int MM_EQ_FLAG       = 3;
  localparam int MM_FLIP          = 2;
  localparam int MM_PWM           = 1;
  localparam int MM_IRQ_EN        = 0;
  localparam logic [7:0] MM_WR_MASK = 8'h7f;

  // Reset values
  localparam logic [7:0]  RESET_REG8  = 8'h00;
  localparam logic [15:0] RESET_CNT   = 16'h0000;
  localparam logic        RESET_PIN   = 1'b1;

  // Count source codes and prescale
  typedef enum logic [1:0] {
    SRC_DIV_A  = 2'h0,
    SRC_DIV_B  = 2'h1,
    SRC_TIMER0 = 2'h2,
    SRC_EXTERN = 2'h3
  } count_src_t;
  localparam int PRESCALE_DIV = 6;

endpackage

// ### pin_sync_edge.sv
// Purpose: Two-flop synchroniser with edge pulses for a pin group
// Assumes: Pins are asynchronous to clk
// Notes:   Edges are seen two to three cycles after the pin moves
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] pinRise,
  output logic      [WIDTH-1:0] pinFall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // Only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle-high reset level, so release makes no false edge
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pinLevel = sync_q;
  assign pinRise  = sync_q & ~prev_q;
  assign pinFall  = ~sync_q & prev_q;

endmodule // pin_sync_edge
`default_nettype wire

// ### count_tick_gen.sv
// Purpose: Increment pulse for the shared counter
// Assumes: Timer-0 overflow and external fall are one-cycle pulses
// Notes:   Prescaler holds while the counter is stopped
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen
  import capcmp_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] sourceSel,
  input  wire logic       countEnable,
  input  wire logic       timer0Overflow,
  input  wire logic       extFall,
  output logic            countTick
);

  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic       preWrap;
  logic       srcTick;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign preWrap = (pre_q == 4'(DIV - 1));
  assign pre_d   = !countEnable ? pre_q :
                   (preWrap ? 4'h0 : pre_q + 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  // Codes 0 and 1 both give the divide-by-6 clock [RQ2]
  assign srcTick = (sourceSel == SRC_TIMER0) ? timer0Overflow :
                   (sourceSel == SRC_EXTERN) ? extFall :
                   preWrap;
  assign countTick = countEnable & srcTick;

endmodule // count_tick_gen
`default_nettype wire

// ### capcmp_sva.sv
// Purpose: Port-level assertions for the capture/compare array
// Assumes: Read data lags the address by one clock edge
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module capcmp_sva
  import capcmp_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic [7:0]      sfrAddr,
  input wire logic [7:0]      sfrWrData,
  input wire logic            sfrWrEn,
  input wire logic [7:0]      sfrRdData,
  input wire logic            irqReq,
  input wire logic            guardReset,
  input wire logic [NMOD-1:0] moduleIoPinOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  sequence s_look(a);
    !sfrWrEn && sfrAddr == a;
  endsequence
  sequence s_mode_wr;
    sfrWrEn && sfrAddr == ADDR_MODE;
  endsequence
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  a_reset_quiet: assert property ($rose(rst_n) |->
    !irqReq && !guardReset && moduleIoPinOe == '0)
    else $error("outputs active after reset");
  a_ctrl_reserved: assert property (
    $past(sfrAddr) == ADDR_CONTROL |-> !sfrRdData[5])
    else $error("control reserved bit set");
  a_mode_reserved: assert property (
    $past(sfrAddr) == ADDR_MODE |-> sfrRdData[5:3] == 3'h0)
    else $error("mode reserved bits set");
  a_modmode_reserved: assert property (
    $past(sfrAddr) inside {[8'hda:8'hde]} |-> !sfrRdData[7])
    else $error("module mode reserved bit set");
  a_mode_readback: assert property (s_mode_wr ##1 s_look(ADDR_MODE)
    |=> sfrRdData == ($past(sfrWrData, 2) & MODE_WR_MASK))
    else $error("mode register readback wrong");
  a_flag_sticky: assert property (
    s_look(ADDR_CONTROL) ##1 s_look(ADDR_CONTROL)
    |=> ($past(sfrRdData) & ~sfrRdData & 8'h9f) == 8'h00)
    else $error("flag cleared without a write");
  a_irq_needs_flag: assert property (
    $past(sfrAddr) == ADDR_CONTROL && (sfrRdData & 8'h9f) == 8'h00
    |-> !irqReq)
    else $error("interrupt without any flag");
  a_count_step: assert property (
    s_look(ADDR_CNT_LOW) ##1 s_look(ADDR_CNT_LOW)
    |=> 8'(sfrRdData - $past(sfrRdData)) <= 8'h01)
    else $error("counter stepped by more than one");
  a_guard_pulse: assert property (guardReset |=> !guardReset)
    else $error("guard reset longer than one cycle");
endmodule // capcmp_sva

bind five_channel_capture_compare_array capcmp_sva #(.NMOD(NMOD)) u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .sfrAddr(sfrAddr),
  .sfrWrData(sfrWrData),
  .sfrWrEn(sfrWrEn),
  .sfrRdData(sfrRdData),
  .irqReq(irqReq),
  .guardReset(guardReset),
  .moduleIoPinOe(moduleIoPinOe)
);
`default_nettype wire

// ### capcmp_pins_model.sv
// Purpose: Far side: module pads and external count source
// Assumes: Pads have no pull; a driven pad shows the block's value
// Notes:   Count source idles high between bursts
`timescale 1ns/1ps
`default_nettype none
module capcmp_pins_model (
  input  wire logic       clk,
  input  wire logic [4:0] padLevel,
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  input  wire logic [7:0] extEdges,
  input  wire logic       extGo,
  output logic      [4:0] pinIn,
  output logic            extPin
);
  int left = 0;
  int ph = 0;
  // Pad n belongs to module n
  assign pinIn = (pinOe & pinOut) | (~pinOe & padLevel);
  initial extPin = 1'b1;
  // Half period of 4 clk: never faster than a quarter of clk
  always @(posedge clk) begin
    if (extGo) begin
      left <= 2 * extEdges;
      ph <= 0;
    end else if (left > 0) begin
      ph <= (ph + 1) % 4;
      if (ph == 3) begin
        extPin <= ~extPin;
        left <= left - 1;
      end
    end
  end
endmodule // capcmp_pins_model
`default_nettype wire

// ### five_channel_capture_compare_array_tb.sv
// Purpose: Register-level tests of the capture/compare array
// Assumes: Inputs change on the falling clock edge
// Notes:   Timer-0 source used where tick timing must be exact
`timescale 1ns/1ps
`default_nettype none
module five_channel_capture_compare_array_tb
  import capcmp_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic       sfrWrEn = 1'b0;
  logic       idleMode = 1'b0;
  logic       timer0Overflow = 1'b0;
  logic [4:0] padLevel = 5'h1f;
  logic [7:0] extEdges = 8'h04;
  logic       extGo = 1'b0;
  logic [7:0] sfrRdData;
  logic       extCountPin;
  logic       irqReq;
  logic       guardReset;
  logic [4:0] pinIn;
  logic [4:0] pinOut;
  logic [4:0] pinOe;
  int         errors = 0;
  int         numChecks = 0;
  int         cycles = 0;
  int         guardCount = 0;

  five_channel_capture_compare_array u_dut (.clk(clk), .rst_n(rst_n),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn),
    .sfrRdData(sfrRdData), .idleMode(idleMode),
    .timer0Overflow(timer0Overflow), .extCountPin(extCountPin),
    .moduleIoPinIn(pinIn), .moduleIoPinOut(pinOut),
    .moduleIoPinOe(pinOe), .irqReq(irqReq), .guardReset(guardReset));
  capcmp_pins_model u_pins (.clk(clk), .padLevel(padLevel),
    .pinOut(pinOut), .pinOe(pinOe), .extEdges(extEdges), .extGo(extGo),
    .pinIn(pinIn), .extPin(extCountPin));

  always #5 clk = ~clk;
  // Ceiling well above the roughly 420 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (guardReset === 1'b1) begin
      guardCount <= guardCount + 1;
    end
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfrAddr = a;
    @(negedge clk);
    chk(sfrRdData, e);
  endtask
  task automatic setCount(input logic [7:0] hi, input logic [7:0] lo);
    wr(ADDR_CNT_HIGH, hi);
    wr(ADDR_CNT_LOW, lo);
  endtask
  task automatic tick0(input int n);
    repeat (n) begin
      @(negedge clk);
      timer0Overflow = 1'b1;
      @(negedge clk);
      timer0Overflow = 1'b0;
    end
  endtask
  task automatic runFor(input int n);
    wr(ADDR_CONTROL, 8'h40);
    repeat (n) @(negedge clk);
    wr(ADDR_CONTROL, 8'h00);
  endtask

  // --------------------------------------------------------------
  // Sequence of tests
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 'hd0; a <= 'hff; a++) begin
      rd(8'(a), 8'h00);
    end
    chk({3'h0, pinOut}, 8'h1f);
    chk({3'h0, pinOe}, 8'h00);
    wr(ADDR_MODE, 8'hff);
    rd(ADDR_MODE, MODE_WR_MASK);
    wr(ADDR_MODE, 8'h00);
    // Divide by 6: stop lands mid-way between ticks
    runFor(19);
    rd(ADDR_CNT_LOW, 8'h03);
    rd(ADDR_CNT_LOW, 8'h03);
    rd(ADDR_CNT_HIGH, 8'h00);
    setCount(8'h00, 8'h00);
    wr(ADDR_MODE, 8'h02);
    runFor(22);
    rd(ADDR_CNT_LOW, 8'h04);
    // Wrap from all ones raises the overflow interrupt
    setCount(8'hff, 8'hfe);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CONTROL, 8'h40);
    repeat (14) @(negedge clk);
    rd(ADDR_CONTROL, 8'hc0);
    rd(ADDR_CONTROL, 8'hc0);
    chk({7'h0, irqReq}, 8'h01);
    wr(ADDR_MODE, 8'h00);
    @(negedge clk);
    chk({7'h0, irqReq}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    // Idle gating with the timer-0 source
    setCount(8'h00, 8'h00);
    wr(ADDR_MODE, 8'h84);
    idleMode = 1'b1;
    wr(ADDR_CONTROL, 8'h40);
    tick0(3);
    rd(ADDR_CNT_LOW, 8'h00);
    wr(ADDR_MODE, 8'h04);
    tick0(3);
    rd(ADDR_CNT_LOW, 8'h03);
    idleMode = 1'b0;
    // External count pin, four falling edges
    setCount(8'h00, 8'h00);
    wr(ADDR_MODE, 8'h06);
    @(negedge clk);
    extGo = 1'b1;
    @(negedge clk);
    extGo = 1'b0;
    repeat (45) @(negedge clk);
    rd(ADDR_CNT_LOW, 8'h04);
    wr(ADDR_CONTROL, 8'h00);
    // Fast output on every module, module 4 guarded
    setCount(8'h00, 8'h00);
    wr(ADDR_MODE, 8'h44);
    for (int n = 0; n < 5; n++) begin
      wr(8'(ADDR_VAL_LOW + n), 8'(2 * n + 2));
      wr(8'(ADDR_VAL_HIGH + n), 8'h00);
      wr(8'(ADDR_MOD_MODE + n), 8'h4d);
    end
    // Drive enable follows the mode register one edge later
    @(negedge clk);
    chk({3'h0, pinOe}, 8'h1f);
    wr(ADDR_CONTROL, 8'h40);
    tick0(10);
    rd(ADDR_CONTROL, 8'h5f);
    chk({3'h0, pinOut}, 8'h00);
    chk({7'h0, irqReq}, 8'h01);
    chk(8'(guardCount), 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    // Capture: pads held low so release makes no edge
    padLevel = 5'h00;
    wr(ADDR_MOD_MODE + 8'h1, 8'h20);
    wr(ADDR_MOD_MODE + 8'h2, 8'h10);
    wr(ADDR_MOD_MODE + 8'h3, 8'h30);
    wr(ADDR_MOD_MODE + 8'h0, 8'h00);
    wr(ADDR_MOD_MODE + 8'h4, 8'h00);
    setCount(8'h12, 8'h34);
    wr(ADDR_CONTROL, 8'h00);
    padLevel = 5'h1f;
    repeat (6) @(negedge clk);
    rd(ADDR_CONTROL, 8'h0a);
    rd(ADDR_VAL_LOW + 8'h1, 8'h34);
    rd(ADDR_VAL_HIGH + 8'h1, 8'h12);
    rd(ADDR_VAL_LOW + 8'h2, 8'h06);
    setCount(8'h56, 8'h78);
    wr(ADDR_CONTROL, 8'h00);
    padLevel = 5'h00;
    repeat (6) @(negedge clk);
    rd(ADDR_CONTROL, 8'h0c);
    rd(ADDR_VAL_LOW + 8'h3, 8'h78);
    rd(ADDR_VAL_HIGH + 8'h2, 8'h56);
    // PWM on module 0: pin high once the low byte reaches the value
    wr(ADDR_VAL_LOW, 8'h80);
    wr(ADDR_VAL_HIGH, 8'h80);
    wr(ADDR_MOD_MODE, 8'h42);
    setCount(8'h00, 8'h10);
    repeat (3) @(negedge clk);
    chk({7'h0, pinOut[0]}, 8'h00);
    chk({7'h0, pinOe[0]}, 8'h01);
    wr(ADDR_CNT_LOW, 8'h90);
    repeat (3) @(negedge clk);
    chk({7'h0, pinOut[0]}, 8'h01);
    final_report();
  end
endmodule // five_channel_capture_compare_array_tb
`default_nettype wire
